// ---- dkc_defines.svh ----
// Purpose: Timing and width constants for the 4K x 1 DRAM pin controller
// Assumes: 100 MHz system clock, 10 ns period
// Notes:   Cycle counts derive from ns figures; least times round up
`ifndef DKC_DEFINES_SVH
`define DKC_DEFINES_SVH

`define DKC_CLK_NS          10
`define DKC_ADDR_W          12
`define DKC_ROW_W           6
// Least chip-enable high time, read or write (ns)
`define DKC_CEH_NS          300
// Least chip-enable high time, read-modify-write (ns)
`define DKC_CEH_RMW_NS      540
// Longest chip-enable high time (ns)
`define DKC_CEH_MAX_NS      4000
// Least chip-enable low time (ns)
`define DKC_CEL_NS          130
// Least write pulse width (ns)
`define DKC_WR_NS           200
// Read access time after chip-enable rise; the pin is sampled one clock later (ns)
`define DKC_ACC_NS          280
// Refresh window (ms), and 64 rows to cover
`define DKC_REF_MS          2
`define DKC_ROWS            64
`define DKC_CEIL(ns)        (((ns) + `DKC_CLK_NS - 1) / `DKC_CLK_NS)
`define DKC_CEH_CYC         `DKC_CEIL(`DKC_CEH_NS)
`define DKC_CEH_RMW_CYC     `DKC_CEIL(`DKC_CEH_RMW_NS)
`define DKC_CEL_CYC         `DKC_CEIL(`DKC_CEL_NS)
`define DKC_WR_CYC          `DKC_CEIL(`DKC_WR_NS)
`define DKC_ACC_CYC         `DKC_CEIL(`DKC_ACC_NS)
// Refresh interval per row, rounded down (window / rows)
`define DKC_REF_INT_CYC     ((`DKC_REF_MS * 1000000) / `DKC_CLK_NS / `DKC_ROWS)

`endif

// ---- dkc_pkg.sv ----
// Purpose: Types for the 4K x 1 DRAM pin controller
// Assumes: Used with dkc_defines.svh
// Notes:   Operation codes on the user request port
package dkc_pkg;
    typedef enum logic [1:0] {
        DKC_OP_READ  = 2'h0,
        DKC_OP_WRITE = 2'h1,
        DKC_OP_RMW   = 2'h2
    } dkc_op_t;
endpackage

// ---- dkc_ctrl.sv ----
// Purpose: Host controller driving a 4K x 1 dynamic RAM through its pins
// Assumes: Device pins are plain levels; read data passes a synchroniser
// Notes:   One access or one refresh per chip-enable pulse
`timescale 1ns/1ps
`include "dkc_defines.svh"

module dkc_ctrl #(
    parameter int REF_INT_CYC = `DKC_REF_INT_CYC  // Cycles between refreshes
) (
    input  wire logic                     i_clk,       // System clock
    input  wire logic                     i_rst,       // Sync reset, high
    input  wire logic                     i_req_valid, // Access request
    output logic                          o_req_ready, // Request taken
    input  wire dkc_pkg::dkc_op_t         i_req_op,    // Read/write/RMW
    input  wire logic [`DKC_ADDR_W-1:0]   i_req_addr,  // Cell address
    input  wire logic                     i_req_wdata, // Bit to write
    output logic                          o_rsp_valid, // Read data pulse
    output logic                          o_rsp_rdata, // True read bit
    output logic                          o_chip_en,   // Chip-enable pin
    output logic                          o_sel_n,     // Select, active low
    output logic                          o_rd_wr_n,   // High read, low write
    output logic [`DKC_ADDR_W-1:0]        o_cell_address_lines, // Address
    output logic                          o_write_data_in,  // Write data pin
    input  wire logic                     i_data_out   // Device data output
);
    import dkc_pkg::*;

    typedef enum logic [2:0] {
        DKC_IDLE, DKC_SETUP, DKC_HIGH, DKC_LOW
    } dkc_state_t;

    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] CEH_CYC  = CNT_W'(`DKC_CEH_CYC);
    localparam logic [CNT_W-1:0] CEHR_CYC = CNT_W'(`DKC_CEH_RMW_CYC);
    localparam logic [CNT_W-1:0] CEL_CYC  = CNT_W'(`DKC_CEL_CYC);
    localparam logic [CNT_W-1:0] WR_CYC   = CNT_W'(`DKC_WR_CYC);
    localparam logic [CNT_W-1:0] ACC_CYC  = CNT_W'(`DKC_ACC_CYC);
    localparam int RC_W = $clog2(REF_INT_CYC + 1);

    dkc_state_t              state_r, state_nxt;
    logic [CNT_W-1:0]        cnt_r, cnt_nxt;
    logic [RC_W-1:0]         ref_cnt_r;
    logic                    ref_due_r;
    logic [`DKC_ROW_W-1:0]   row_r;
    logic                    is_ref_r;
    dkc_op_t                 op_r;
    logic                    din_s1_r, din_s2_r;
    logic                    rdata_r, rsp_valid_r;
    logic                    sample_d_r;

    // Decode of the current cycle phase
    wire ref_tick   = (ref_cnt_r == RC_W'(REF_INT_CYC - 1));
    wire take_ref   = (state_r == DKC_IDLE) && ref_due_r;
    wire take_req   = (state_r == DKC_IDLE) && !ref_due_r && i_req_valid;
    wire is_wr_op   = (op_r == DKC_OP_WRITE);
    wire is_rmw_op  = (op_r == DKC_OP_RMW);
    wire [CNT_W-1:0] ceh_len = is_rmw_op ? CEHR_CYC : CEH_CYC;
    // RMW reads first, then drops read/write for the write pulse
    wire wr_phase   = !is_ref_r && (is_wr_op ||
                      (is_rmw_op && cnt_r >= ACC_CYC + 1'b1));
    // Arm at count ACC_CYC + 1 of a read or RMW; a plain read has no later high cycle
    wire sample_rd  = (state_r == DKC_HIGH) && !is_ref_r &&
                      !is_wr_op && (cnt_r == ACC_CYC + 1'b1);
    wire high_done  = (state_r == DKC_HIGH) && (cnt_r == ceh_len - 1'b1);
    wire low_done   = (state_r == DKC_LOW) && (cnt_r == CEL_CYC - 1'b1);

    assign o_req_ready = take_req;
    assign o_rsp_valid = rsp_valid_r;
    assign o_rsp_rdata = rdata_r;

    // Next-state logic for one chip-enable cycle
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 1'b1;
        unique case (state_r)
            DKC_IDLE: begin
                cnt_nxt = '0;
                if (take_ref || take_req) begin
                    state_nxt = DKC_SETUP;
                end
            end
            DKC_SETUP: begin
                // Address and select settle a cycle before the rise
                cnt_nxt   = '0;
                state_nxt = DKC_HIGH;
            end
            DKC_HIGH: begin
                if (high_done) begin
                    cnt_nxt   = '0;
                    state_nxt = DKC_LOW;
                end
            end
            DKC_LOW: begin
                // Precharge time before the next cycle
                if (low_done) begin
                    state_nxt = DKC_IDLE;
                end
            end
        endcase
    end

    // State and counter
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= DKC_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Refresh timer; a due flag defers refresh past an active access
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ref_cnt_r <= '0;
            ref_due_r <= 1'b0;
        end else begin
            ref_cnt_r <= ref_tick ? '0 : ref_cnt_r + 1'b1;
            if (ref_tick) begin
                ref_due_r <= 1'b1;
            end else if (take_ref) begin
                ref_due_r <= 1'b0;
            end
        end
    end

    // Row counter steps once per refresh cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            row_r <= '0;
        end else if (take_ref) begin
            row_r <= row_r + 1'b1;
        end
    end

    // Pin registers, loaded at cycle start; address and write data held till next, select raised in idle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            is_ref_r             <= 1'b0;
            op_r                 <= DKC_OP_READ;
            o_cell_address_lines <= '0;
            o_write_data_in      <= 1'b0;
            o_sel_n              <= 1'b1;
        end else if (take_ref) begin
            is_ref_r             <= 1'b1;
            op_r                 <= DKC_OP_READ;
            // Column bits are don't-care; zero keeps them quiet
            o_cell_address_lines <= {{(`DKC_ADDR_W-`DKC_ROW_W){1'b0}},
                                     row_r};
            o_sel_n              <= 1'b1;
        end else if (take_req) begin
            is_ref_r             <= 1'b0;
            op_r                 <= i_req_op;
            o_cell_address_lines <= i_req_addr;
            o_write_data_in      <= i_req_wdata;
            o_sel_n              <= 1'b0;
        end else if (state_r == DKC_IDLE) begin
            o_sel_n              <= 1'b1;  // Deselect between cycles
        end
    end

    // Chip-enable and read/write pins; write pulse ends with enable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_chip_en <= 1'b0;
            o_rd_wr_n <= 1'b1;
        end else begin
            o_chip_en <= (state_nxt == DKC_HIGH);
            o_rd_wr_n <= !((state_nxt == DKC_HIGH) &&
                           (state_r == DKC_HIGH) && wr_phase);
        end
    end

    // Two-flop synchroniser on the device output
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            din_s1_r <= i_data_out;
            din_s2_r <= din_s1_r;
        end
    end

    // Take the bit one cycle after arming: the synchroniser then shows
    // the pin as it stood 290 ns after the rise, chip-enable still high.
    // Device returns data inverted
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sample_d_r  <= 1'b0;
            rdata_r     <= 1'b0;
            rsp_valid_r <= 1'b0;
        end else begin
            sample_d_r  <= sample_rd;
            rsp_valid_r <= sample_d_r;
            if (sample_d_r) begin
                rdata_r <= !din_s2_r;
            end
        end
    end
endmodule

// ---- dkc_ctrl_asserts.sv ----
// Purpose: Pin-side checks, plus a read-answer check, on every dkc_ctrl
// Assumes: Names match the controller ports
// Notes:   Refresh spacing follows REF_INT_CYC
`timescale 1ns/1ps
`include "dkc_defines.svh"
module dkc_ctrl_chk #(
    parameter int REF_INT_CYC = 200 // Refresh spacing
) (
    input wire logic                   i_clk,       // Clock
    input wire logic                   i_rst,       // Reset
    input wire logic                   i_req_valid, // Request
    input wire logic                   o_req_ready, // Taken
    input wire dkc_pkg::dkc_op_t       i_req_op,    // Op
    input wire logic                   o_rsp_valid, // Answer
    input wire logic                   o_chip_en,   // Enable
    input wire logic                   o_sel_n,     // Select
    input wire logic                   o_rd_wr_n,   // Mode
    input wire logic [`DKC_ADDR_W-1:0] o_cell_address_lines, // Pins
    input wire logic                   o_write_data_in // Data
);
    import dkc_pkg::*;
    logic        ce_q_r;
    logic [15:0] gap_r;
    logic [5:0]  row_r;
    logic        seen_r;
    // A deselected enable rise starts a refresh
    wire ref_go = o_chip_en && !ce_q_r && o_sel_n;
    // Gap since last refresh, and its row
    always_ff @(posedge i_clk) begin
        ce_q_r <= o_chip_en;
        gap_r  <= (i_rst || ref_go) ? 16'h0 : gap_r + 16'h1;
        seen_r <= !i_rst && (seen_r || ref_go);
        if (ref_go) row_r <= o_cell_address_lines[5:0];
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_addr_held: assert property (
        o_chip_en |-> $stable(o_cell_address_lines))
        else $error("address moved in enable high");
    a_wdata_held: assert property (
        o_chip_en && !o_rd_wr_n |-> $stable(o_write_data_in))
        else $error("write data moved in write");
    a_sel_held: assert property (
        o_chip_en |-> $stable(o_sel_n))
        else $error("select moved in enable high");
    a_refresh_read: assert property (
        o_chip_en && o_sel_n |-> o_rd_wr_n)
        else $error("deselected cycle in write mode");
    a_refresh_due: assert property (
        gap_r < 16'(REF_INT_CYC + 100))
        else $error("refresh overdue");
    a_row_step: assert property (
        ref_go && seen_r |-> o_cell_address_lines[5:0] == row_r + 6'h1)
        else $error("refresh row did not advance");
    a_read_answer: assert property (
        i_req_valid && o_req_ready && i_req_op != DKC_OP_WRITE
        |-> ##[33:34] o_rsp_valid)
        else $error("read answer late");
endmodule
bind dkc_ctrl dkc_ctrl_chk #(
    .REF_INT_CYC(REF_INT_CYC)
) i_chk (
    .i_clk                (i_clk),
    .i_rst                (i_rst),
    .i_req_valid          (i_req_valid),
    .o_req_ready          (o_req_ready),
    .i_req_op             (i_req_op),
    .o_rsp_valid          (o_rsp_valid),
    .o_chip_en            (o_chip_en),
    .o_sel_n              (o_sel_n),
    .o_rd_wr_n            (o_rd_wr_n),
    .o_cell_address_lines (o_cell_address_lines),
    .o_write_data_in      (o_write_data_in)
);

// ---- dkc_dram_model.sv ----
// Purpose: Behavioural 4K x 1 dynamic RAM at its pins
// Assumes: Pins change just after the clock edge
// Notes:   A floating output toggles, never holds
`timescale 1ns/1ps
module dkc_dram_model (
    input  wire logic        i_clk,     // Clock
    input  wire logic        i_chip_en, // Enable
    input  wire logic        i_sel_n,   // Select
    input  wire logic        i_rd_wr_n, // Mode
    input  wire logic [11:0] i_addr,    // Address
    input  wire logic        i_wdata,   // Data in
    output logic             o_dout     // Data out
);
    logic        cells [4096];
    logic [11:0] addr_r;
    logic        sel_n_r = 1'b1;
    logic        ce_q_r = 1'b0;
    logic        tgl_r = 1'b0;
    int          cnt_r = 0;
    // Latch at enable rise; store while high
    always @(posedge i_clk) begin
        ce_q_r <= i_chip_en;
        tgl_r  <= ~tgl_r;
        if (i_chip_en && !ce_q_r) begin
            addr_r  <= i_addr;
            sel_n_r <= i_sel_n;
            cnt_r   <= 0;
        end else if (i_chip_en) begin
            cnt_r <= cnt_r + 1;
            if (!sel_n_r && !i_rd_wr_n)
                cells[addr_r] <= i_wdata;
        end
    end
    // Float when idle or unselected; low, then inverted
    assign o_dout = (!i_chip_en || sel_n_r) ? tgl_r :
        // Low until 27 cycles past the pin rise, which is count 26 here
        (cnt_r < 26 || !ce_q_r) ? 1'b0 :
        ~cells[addr_r];
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for dkc_ctrl
// Assumes: Device model on the pin side
// Notes:   Short refresh interval keeps the run brief
`timescale 1ns/1ps
module testbench;
    import dkc_pkg::*;
    localparam int RI = 200;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0;
    logic        i_req_wdata = 1'b0, ce_seen = 1'b0;
    dkc_op_t     i_req_op = DKC_OP_READ;
    logic [11:0] i_req_addr = 12'h000, o_cell_address_lines, adr [8];
    logic        o_req_ready, o_rsp_valid, o_rsp_rdata, o_chip_en;
    logic        o_sel_n, o_rd_wr_n, o_write_data_in, i_data_out;
    logic        shadow [4096];
    int          fail_count = 0, checks = 0, cyc = 0, nref = 0;
    always #5 i_clk = ~i_clk;
    dkc_ctrl #(.REF_INT_CYC(RI)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
        .o_req_ready(o_req_ready), .i_req_op(i_req_op),
        .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
        .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
        .o_chip_en(o_chip_en), .o_sel_n(o_sel_n), .o_rd_wr_n(o_rd_wr_n),
        .o_cell_address_lines(o_cell_address_lines),
        .o_write_data_in(o_write_data_in), .i_data_out(i_data_out));
    dkc_dram_model i_mem (.i_clk(i_clk), .i_chip_en(o_chip_en),
        .i_sel_n(o_sel_n), .i_rd_wr_n(o_rd_wr_n),
        .i_addr(o_cell_address_lines), .i_wdata(o_write_data_in),
        .o_dout(i_data_out));
    function automatic logic exp_bit(input logic [11:0] a);
        return shadow[a];
    endfunction
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %b want %b", $time, got, exp);
        end
    endtask
    // One access; waits are bounded so a stall shows up
    task automatic access(input dkc_op_t op, input logic [11:0] a,
                          input logic d);
        int n;
        n = 0;
        @(posedge i_clk);
        #1;
        i_req_op    = op;
        i_req_addr  = a;
        i_req_wdata = d;
        i_req_valid = 1'b1;
        @(negedge i_clk);
        while (o_req_ready !== 1'b1 && n < 300) begin
            n++;
            @(negedge i_clk);
        end
        cmp_bit(o_req_ready, 1'b1);
        @(posedge i_clk);
        #1 i_req_valid = 1'b0;
        if (op != DKC_OP_WRITE) begin
            n = 0;
            @(negedge i_clk);
            while (o_rsp_valid !== 1'b1 && n < 60) begin
                n++;
                @(negedge i_clk);
            end
            cmp_bit(o_rsp_valid, 1'b1);
            cmp_bit(o_rsp_rdata, exp_bit(a));
        end
        if (op != DKC_OP_READ) shadow[a] = d;
    endtask
    // Hang guard and refresh tally; pins read mid-cycle where settled
    always @(negedge i_clk) begin
        cyc++;
        if (o_chip_en && !ce_seen && o_sel_n) nref++;
        ce_seen = o_chip_en;
        if (cyc == 10000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'h864C));
        repeat (5) @(posedge i_clk);
        #1 i_rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            adr[i] = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
            access(DKC_OP_WRITE, adr[i], 1'($urandom));
        end
        $display("test write done");
        for (int i = 7; i >= 0; i--) access(DKC_OP_READ, adr[i], 1'b0);
        $display("test read done");
        for (int i = 0; i < 8; i++)
            access(DKC_OP_RMW, adr[i], ~exp_bit(adr[i]));
        for (int i = 0; i < 8; i++) access(DKC_OP_READ, adr[i], 1'b0);
        $display("test read-modify-write done");
        repeat (4 * RI) @(posedge i_clk);
        cmp_bit(nref >= cyc / (RI + 100), 1'b1);
        $display("test refresh done");
        close_out();
    end
endmodule
